// [design/fault_pkg.sv]
/*
  fault_pkg: constants, register offsets, field positions and carrier types
  for the processor fault classification and escalation unit.
  Assumes a single core clock and a plain register port with read data
  valid one cycle after the read strobe.
*/
package fault_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_PROTECT_CAUSE = 8'h00;
  localparam logic [7:0] OFS_BUS_CAUSE     = 8'h04;
  localparam logic [7:0] OFS_USAGE_CAUSE   = 8'h08;
  localparam logic [7:0] OFS_HARD_CAUSE    = 8'h0c;
  localparam logic [7:0] OFS_PROTECT_ADDR  = 8'h10;
  localparam logic [7:0] OFS_BUS_ADDR      = 8'h14;
  localparam logic [7:0] OFS_CONTROL       = 8'h18;
  localparam logic [7:0] OFS_PRIORITY      = 8'h1c;
  localparam logic [7:0] OFS_STATE         = 8'h20;

  // protect cause bits
  localparam int PF_INSTR   = 0;
  localparam int PF_DATA    = 1;
  localparam int PF_UNSTACK = 3;
  localparam int PF_STACK   = 4;
  localparam int PF_ADDR_OK = 7;
  // bus cause bits
  localparam int BF_FETCH   = 0;
  localparam int BF_EXACT   = 1;
  localparam int BF_INEXACT = 2;
  localparam int BF_UNSTACK = 3;
  localparam int BF_STACK   = 4;
  localparam int BF_ADDR_OK = 7;
  // usage cause bits
  localparam int UF_UNDEF   = 0;
  localparam int UF_STATE   = 1;
  localparam int UF_RETURN  = 2;
  localparam int UF_COPROC  = 3;
  localparam int UF_ALIGN   = 8;
  localparam int UF_DIVZERO = 9;
  // hard cause bits
  localparam int HF_VECTOR  = 1;
  localparam int HF_ESCALATED_FAULT_FLAG  = 30;
  // control bits
  localparam int CT_PROTECT_EN = 16;
  localparam int CT_BUS_EN     = 17;
  localparam int CT_USAGE_EN   = 18;
  // priority fields: protect [7:0], bus [15:8], usage [23:16]
  localparam int PRI_W = 8;

  // reset values
  localparam logic [31:0] CONTROL_RESET  = 32'h0000_0000;
  localparam logic [31:0] PRIORITY_RESET = 32'h0000_0000;

  // fixed priority levels; lower number is more urgent
  localparam logic signed [9:0] PRI_RESET = -10'sd3;
  localparam logic signed [9:0] PRI_NMI   = -10'sd2;
  localparam logic signed [9:0] PRI_HARD  = -10'sd1;
  localparam logic signed [9:0] PRI_IDLE  = 10'sd256;

  typedef enum logic [1:0] {
    KIND_NONE    = 2'b00,
    KIND_PROTECT = 2'b01,
    KIND_BUS     = 2'b10,
    KIND_USAGE   = 2'b11
  } fault_kind_t;

  // fault reports from pipeline and bus interface, one-cycle pulses
  typedef struct packed {
    logic        vector_bus_err;
    logic        fetch_bus_err;
    logic        exact_bus_err;
    logic        inexact_bus_err;
    logic        stack_bus_err;
    logic        unstack_bus_err;
    logic        instr_protect;
    logic        execute_never;
    logic        data_protect;
    logic        stack_protect;
    logic        unstack_protect;
    logic        coproc_access;
    logic        undefined_op;
    logic        bad_isa;
    logic        bad_return;
    logic        unaligned;
    logic        div_zero;
    logic [31:0] addr;
  } fault_report_t;

  // what the prioritiser is currently running
  typedef struct packed {
    logic             in_handler;
    logic             in_hard;
    logic             in_nmi;
    logic             stacking_bus;
    logic signed [9:0] level;
    fault_kind_t      kind;
  } exec_state_t;

  typedef enum logic [1:0] {
    RUN_NORMAL = 2'b00,
    RUN_LOCKUP = 2'b01
  } run_state_t;

endpackage : fault_pkg

// [design/fault_unit.sv]
/*
  fault_unit: classifies fault reports into protect, bus, usage and hard
  faults, keeps sticky cause flags and fault addresses, escalates and locks up.
  Assumes fault reports are single-cycle pulses synchronous to clk_i and the
  prioritiser acts on the take strobes in the cycle they are raised.
*/
`timescale 1ns/1ps
module fault_unit
  import fault_pkg::*;
(
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // fault reports and execution context
  input  wire fault_report_t report_i,
  input  wire exec_state_t   exec_i,
  // register port
  input  wire logic [7:0]    addr_i,
  input  wire logic [31:0]   wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic [31:0]        rdata_o,
  // to the prioritiser
  output logic               take_protect_o,
  output logic               take_bus_o,
  output logic               take_usage_o,
  output logic               take_hard_o,
  output logic signed [9:0]  fault_level_o,
  output logic               lockup_o,
  output logic               halt_exec_o
);

  logic [7:0]  protect_cause;
  logic [7:0]  bus_cause;
  logic [15:0] usage_cause;
  logic [31:0] hard_cause;
  logic [31:0] protect_addr;
  logic [31:0] bus_addr;
  logic [31:0] control;
  logic [31:0] priority_cfg;
  run_state_t  run_state;

  logic        raw_protect;
  logic        raw_bus;
  logic        raw_usage;
  logic        want_protect;
  logic        want_bus;
  logic        want_usage;
  logic        esc_protect;
  logic        esc_bus;
  logic        esc_usage;
  logic        any_escalated;
  logic        hard_event;
  logic        hard_blocked;

  // software priority of one configurable fault kind
  function automatic logic signed [9:0] level_of(input fault_kind_t k,
                                                 input logic [31:0] pri);
    logic signed [9:0] lv;
    lv = PRI_IDLE;
    unique case (k)
      KIND_PROTECT: lv = $signed({2'b00, pri[PRI_W-1:0]});
      KIND_BUS:     lv = $signed({2'b00, pri[2*PRI_W-1:PRI_W]});
      KIND_USAGE:   lv = $signed({2'b00, pri[3*PRI_W-1:2*PRI_W]});
      KIND_NONE:    lv = PRI_IDLE;
    endcase
    return lv;
  endfunction : level_of

  // escalation test for a configurable fault of kind k
  function automatic logic must_escalate(input fault_kind_t k, input logic enabled,
                                         input exec_state_t ex,
                                         input logic [31:0] pri);
    logic same;
    logic lower;
    same  = ex.in_handler && (ex.kind == k);
    lower = ex.in_handler && (level_of(k, pri) >= ex.level);
    return same || lower || !enabled;
  endfunction : must_escalate

  // classification of raw causes
  always_comb begin
    raw_protect = report_i.instr_protect | report_i.execute_never
                | report_i.data_protect | report_i.stack_protect
                | report_i.unstack_protect;
    raw_bus     = report_i.fetch_bus_err | report_i.exact_bus_err
                | report_i.inexact_bus_err | report_i.stack_bus_err
                | report_i.unstack_bus_err;
    raw_usage   = report_i.coproc_access | report_i.undefined_op
                | report_i.bad_isa | report_i.bad_return
                | report_i.unaligned | report_i.div_zero;
  end

  // escalation decisions; bus stacking into own handler never escalates
  always_comb begin
    esc_protect = raw_protect
                && must_escalate(KIND_PROTECT, control[CT_PROTECT_EN], exec_i, priority_cfg);
    esc_bus     = raw_bus && !(exec_i.stacking_bus && report_i.stack_bus_err)
                && must_escalate(KIND_BUS, control[CT_BUS_EN], exec_i, priority_cfg);
    esc_usage   = raw_usage
                && must_escalate(KIND_USAGE, control[CT_USAGE_EN], exec_i, priority_cfg);
    any_escalated = esc_protect | esc_bus | esc_usage;
    want_protect  = raw_protect && !esc_protect;
    want_bus      = raw_bus && !esc_bus;
    want_usage    = raw_usage && !esc_usage;
    hard_event    = report_i.vector_bus_err | any_escalated;
    // hard fault yields to nmi, and never preempts itself
    hard_blocked  = exec_i.in_nmi;
  end

  // take strobes; nothing is taken once locked up
  always_comb begin
    take_protect_o = want_protect && run_state == RUN_NORMAL;
    take_bus_o     = want_bus && run_state == RUN_NORMAL;
    take_usage_o   = want_usage && run_state == RUN_NORMAL;
    take_hard_o    = hard_event && !exec_i.in_hard && !hard_blocked
                   && run_state == RUN_NORMAL;
    fault_level_o  = take_hard_o    ? PRI_HARD :
                     take_protect_o ? level_of(KIND_PROTECT, priority_cfg) :
                     take_bus_o     ? level_of(KIND_BUS, priority_cfg) :
                     take_usage_o   ? level_of(KIND_USAGE, priority_cfg) : PRI_IDLE;
    lockup_o       = run_state == RUN_LOCKUP;
    halt_exec_o    = run_state == RUN_LOCKUP;
  end

  // lockup: left only through reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_state <= RUN_NORMAL;
    end else if (hard_event && exec_i.in_hard) begin
      run_state <= RUN_LOCKUP;
    end
  end

  // software configuration: enables and priorities
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      control      <= CONTROL_RESET;
      priority_cfg <= PRIORITY_RESET;
    end else if (wr_i) begin
      if (addr_i == OFS_CONTROL) begin
        control <= wdata_i & 32'h0007_0000;
      end
      if (addr_i == OFS_PRIORITY) begin
        priority_cfg <= {8'h00, wdata_i[23:0]};
      end
    end
  end

  // protect cause: write one to clear, a new event wins over the clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      protect_cause <= 8'h00;
      protect_addr  <= 32'h0000_0000;
    end else begin
      protect_cause <= (protect_cause
                        & ~((wr_i && addr_i == OFS_PROTECT_CAUSE) ? wdata_i[7:0] : 8'h00))
                     | {3'b000, report_i.stack_protect, report_i.unstack_protect, 1'b0,
                        report_i.data_protect,
                        report_i.instr_protect | report_i.execute_never};
      if (report_i.data_protect && !protect_cause[PF_ADDR_OK]) begin
        protect_addr           <= report_i.addr;
        protect_cause[PF_ADDR_OK] <= 1'b1;
      end
    end
  end

  // bus cause and bus address
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_cause <= 8'h00;
      bus_addr  <= 32'h0000_0000;
    end else begin
      bus_cause <= (bus_cause
                    & ~((wr_i && addr_i == OFS_BUS_CAUSE) ? wdata_i[7:0] : 8'h00))
                 | {3'b000, report_i.stack_bus_err, report_i.unstack_bus_err,
                    report_i.inexact_bus_err, report_i.exact_bus_err,
                    report_i.fetch_bus_err};
      if (report_i.exact_bus_err && !bus_cause[BF_ADDR_OK]) begin
        bus_addr              <= report_i.addr;
        bus_cause[BF_ADDR_OK] <= 1'b1;
      end
    end
  end

  // usage cause
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      usage_cause <= 16'h0000;
    end else begin
      usage_cause <= (usage_cause
                      & ~((wr_i && addr_i == OFS_USAGE_CAUSE) ? wdata_i[15:0] : 16'h0000))
                   | {6'h00, report_i.div_zero, report_i.unaligned, 4'h0,
                      report_i.coproc_access, report_i.bad_return,
                      report_i.bad_isa, report_i.undefined_op};
    end
  end

  // hard cause
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hard_cause <= 32'h0000_0000;
    end else begin
      hard_cause <= (hard_cause
                     & ~((wr_i && addr_i == OFS_HARD_CAUSE) ? wdata_i : 32'h0000_0000))
                  | ({31'h0, report_i.vector_bus_err} << HF_VECTOR)
                  | ({31'h0, any_escalated} << HF_ESCALATED_FAULT_FLAG);
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      unique case (addr_i)
        OFS_PROTECT_CAUSE: rdata_o <= {24'h0, protect_cause};
        OFS_BUS_CAUSE:     rdata_o <= {24'h0, bus_cause};
        OFS_USAGE_CAUSE:   rdata_o <= {16'h0, usage_cause};
        OFS_HARD_CAUSE:    rdata_o <= hard_cause;
        OFS_PROTECT_ADDR:  rdata_o <= protect_addr;
        OFS_BUS_ADDR:      rdata_o <= bus_addr;
        OFS_CONTROL:       rdata_o <= control;
        OFS_PRIORITY:      rdata_o <= priority_cfg;
        OFS_STATE:         rdata_o <= {31'h0, run_state == RUN_LOCKUP};
        default:           rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

endmodule : fault_unit

// [bench/fault_unit_assertions.sv]
/*
  fault_unit_checker: concurrent checks on the fault unit's ports.
  Assumes one clk_i domain and at most one report bit per cycle.
*/
`timescale 1ns/1ps
module fault_unit_checker
  import fault_pkg::*;
(
  // clock and reset
  input wire logic              clk_i,
  input wire logic              rst_i,
  // watched ports
  input wire fault_report_t     report_i,
  input wire exec_state_t       exec_i,
  input wire logic              take_protect_o,
  input wire logic              take_bus_o,
  input wire logic              take_usage_o,
  input wire logic              take_hard_o,
  input wire logic signed [9:0] fault_level_o,
  input wire logic              lockup_o,
  input wire logic              halt_exec_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // take vector and a context in which a fault must be taken
  logic [3:0] takes;
  logic       free;
  assign takes = {take_protect_o, take_bus_o, take_usage_o, take_hard_o};
  assign free  = !lockup_o && !exec_i.in_hard && !exec_i.in_nmi;

  property p_lock_hold; lockup_o |=> lockup_o; endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lockup dropped");
  property p_lock_quiet; lockup_o |-> takes == 4'h0 && halt_exec_o; endproperty
  a_lock_quiet: assert property (p_lock_quiet) else $error("lockup not quiet");
  property p_lock_entry;
    report_i.vector_bus_err && exec_i.in_hard && !lockup_o |=> lockup_o [*3];
  endproperty
  a_lock_entry: assert property (p_lock_entry) else $error("no lockup");
  property p_vector; report_i.vector_bus_err && free |-> take_hard_o; endproperty
  a_vector: assert property (p_vector) else $error("vector error not hard");
  property p_hard_lvl; take_hard_o |-> fault_level_o == PRI_HARD; endproperty
  a_hard_lvl: assert property (p_hard_lvl) else $error("hard level wrong");
  property p_nmi; exec_i.in_nmi |-> !take_hard_o; endproperty
  a_nmi: assert property (p_nmi) else $error("hard taken over nmi");
  property p_stack;
    report_i.stack_bus_err && exec_i.stacking_bus && free |-> take_bus_o && !take_hard_o;
  endproperty
  a_stack: assert property (p_stack) else $error("stacking fault escalated");
  property p_usage; report_i.div_zero && free |-> $onehot({take_usage_o, take_hard_o}); endproperty
  a_usage: assert property (p_usage) else $error("divide fault lost");
  property p_bus;
    report_i.exact_bus_err && free |-> $onehot({take_bus_o, take_hard_o});
  endproperty
  a_bus: assert property (p_bus) else $error("bus fault lost");
  property p_same;
    report_i.data_protect && free && exec_i.in_handler && exec_i.kind == KIND_PROTECT
      |-> take_hard_o;
  endproperty
  a_same: assert property (p_same) else $error("same kind not escalated");
  property p_idle; report_i[48:32] == 17'h0 |-> takes == 4'h0 && fault_level_o == PRI_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("take without source");
endmodule : fault_unit_checker

bind fault_unit fault_unit_checker u_chk (.clk_i, .rst_i, .report_i, .exec_i, .take_protect_o,
  .take_bus_o, .take_usage_o, .take_hard_o, .fault_level_o, .lockup_o, .halt_exec_o);

// [bench/core_model.sv]
/*
  core_model: stands in for pipeline, bus interface and prioritiser.
  Assumes the bench calls its tasks from one process.
*/
`timescale 1ns/1ps
module core_model
  import fault_pkg::*;
(
  // clock
  input  wire logic    clk_i,
  // to the fault unit
  output fault_report_t report_o,
  output exec_state_t   exec_o
);
  // quiet, thread mode until asked
  initial begin
    report_o = '0;
    exec_o   = '{0, 0, 0, 0, PRI_IDLE, KIND_NONE};
  end
  // one report pulse with its context
  task automatic fire(input fault_report_t r, input exec_state_t e);
    @(posedge clk_i);
    report_o <= r;
    exec_o   <= e;
    #1;
  endtask : fire
  // released address shows the inverse so stale data cannot pass
  task automatic idle();
    @(posedge clk_i);
    report_o <= {17'h0, ~report_o.addr};
    #1;
  endtask : idle
endmodule : core_model

// [bench/fault_unit_tb.sv]
/*
  fault_unit_tb: directed scenarios for the fault unit.
  Assumes core_model drives reports and the checker is bound to the design.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("FAIL t=%0t got %h exp %h", $time, g, e); \
  end \
end
module fault_unit_tb
  import fault_pkg::*;
;
  logic              clk_i, rst_i, wr_i, rd_i;
  logic [7:0]        addr_i;
  logic [31:0]       wdata_i, rdata_o;
  wire logic [3:0]   takes;
  logic signed [9:0] fault_level_o;
  logic              lockup_o, halt_exec_o;
  fault_report_t     report;
  exec_state_t       exec;
  int                error_cnt, num_checks;

  core_model core (.clk_i(clk_i), .report_o(report), .exec_o(exec));
  fault_unit DUT (.clk_i(clk_i), .rst_i(rst_i), .report_i(report), .exec_i(exec),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .take_protect_o(takes[3]), .take_bus_o(takes[2]), .take_usage_o(takes[1]),
    .take_hard_o(takes[0]), .fault_level_o(fault_level_o), .lockup_o(lockup_o),
    .halt_exec_o(halt_exec_o));

  // 100 MHz core clock
  always #5 clk_i = ~clk_i;

  function automatic fault_report_t rep(int k, logic [31:0] a);
    return {17'h1 << k, a};
  endfunction : rep
  function automatic exec_state_t ex(logic h, logic hd, logic n, logic s,
                                     logic signed [9:0] l, fault_kind_t k);
    return '{h, hd, n, s, l, k};
  endfunction : ex
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  // takes are combinational, judged in the pulse cycle
  task automatic hit(input fault_report_t r, input exec_state_t e,
                     input logic [3:0] tk, input logic signed [9:0] lv);
    core.fire(r, e);
    `CHK(takes, tk)
    `CHK(fault_level_o, lv)
    core.idle();
  endtask : hit

  task automatic t_regs();
    logic [31:0] d;
    for (int i = 0; i < 10; i++) begin
      rd(8'(i * 4), d);
      `CHK(d, 32'h0)
    end
    wr(OFS_PRIORITY, 32'h0030_2010);
    wr(OFS_CONTROL, 32'h0007_0000);
    rd(OFS_PRIORITY, d);
    `CHK(d, 32'h0030_2010)
    rd(OFS_CONTROL, d);
    `CHK(d, 32'h0007_0000)
    $display("done t_regs");
  endtask : t_regs

  task automatic t_causes();
    int          bitn [16] = '{UF_DIVZERO, UF_ALIGN, UF_RETURN, UF_STATE, UF_UNDEF, UF_COPROC,
                              PF_UNSTACK, PF_STACK, PF_DATA, PF_INSTR, PF_INSTR,
                              BF_UNSTACK, BF_STACK, BF_INEXACT, BF_EXACT, BF_FETCH};
    logic [7:0]  ofs;
    logic [31:0] d;
    for (int k = 0; k < 16; k++) begin
      ofs = k < 6 ? OFS_USAGE_CAUSE : k < 11 ? OFS_PROTECT_CAUSE : OFS_BUS_CAUSE;
      hit(rep(k, 32'h0), ex(0, 0, 0, 0, PRI_IDLE, KIND_NONE), k < 6 ? 4'h2 : k < 11 ? 4'h8 :
          4'h4, k < 6 ? 10'sd48 : k < 11 ? 10'sd16 : 10'sd32);
      rd(ofs, d);
      `CHK(d[bitn[k]], 1'b1)
      wr(ofs, d);
      rd(ofs, d);
      `CHK(d, 32'h0)
    end
    $display("done t_causes");
  endtask : t_causes

  task automatic t_addr();
    logic [31:0] d;
    hit(rep(14, 32'h1000_0040), ex(0, 0, 0, 0, PRI_IDLE, KIND_NONE), 4'h4, 10'sd32);
    hit(rep(14, 32'h2000_0080), ex(0, 0, 0, 0, PRI_IDLE, KIND_NONE), 4'h4, 10'sd32);
    hit(rep(8, 32'h3000_00c0), ex(0, 0, 0, 0, PRI_IDLE, KIND_NONE), 4'h8, 10'sd16);
    hit(rep(1, 32'h4000_0100), ex(0, 0, 0, 0, PRI_IDLE, KIND_NONE), 4'h2, 10'sd48);
    rd(OFS_BUS_ADDR, d);
    `CHK(d, 32'h1000_0040)
    rd(OFS_PROTECT_ADDR, d);
    `CHK(d, 32'h3000_00c0)
    rd(OFS_BUS_CAUSE, d);
    `CHK(d, 32'h0000_0082)
    rd(OFS_USAGE_CAUSE, d);
    `CHK(d, 32'h0000_0100)
    $display("done t_addr");
  endtask : t_addr

  task automatic t_escal();
    logic [31:0] d;
    hit(rep(8, 0), ex(1, 0, 0, 0, 10'sd16, KIND_PROTECT), 4'h1, PRI_HARD);
    hit(rep(0, 0), ex(1, 0, 0, 0, 10'sd32, KIND_BUS), 4'h1, PRI_HARD);
    hit(rep(14, 0), ex(1, 0, 0, 0, 10'sd48, KIND_USAGE), 4'h4, 10'sd32);
    hit(rep(0, 0), ex(1, 0, 0, 0, 10'sd16, KIND_NONE), 4'h1, PRI_HARD);
    hit(rep(16, 0), ex(1, 0, 0, 0, 10'sd48, KIND_USAGE), 4'h1, PRI_HARD);
    hit(rep(12, 0), ex(1, 0, 0, 1, 10'sd32, KIND_BUS), 4'h4, 10'sd32);
    wr(OFS_CONTROL, 32'h0);
    hit(rep(5, 0), ex(0, 0, 0, 0, PRI_IDLE, KIND_NONE), 4'h1, PRI_HARD);
    rd(OFS_HARD_CAUSE, d);
    `CHK(d, 32'h4000_0002)
    $display("done t_escal");
  endtask : t_escal

  task automatic t_lock();
    logic [31:0] d;
    hit(rep(16, 0), ex(1, 0, 1, 0, PRI_NMI, KIND_NONE), 4'h0, PRI_IDLE);
    hit(rep(16, 0), ex(1, 1, 0, 0, PRI_HARD, KIND_NONE), 4'h0, PRI_IDLE);
    `CHK({lockup_o, halt_exec_o}, 2'b11)
    hit(rep(15, 0), ex(0, 0, 0, 0, PRI_IDLE, KIND_NONE), 4'h0, PRI_IDLE);
    rd(OFS_STATE, d);
    `CHK(d, 32'h1)
    // only reset leaves lockup
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 `CHK({lockup_o, halt_exec_o}, 2'b00)
    $display("done t_lock");
  endtask : t_lock

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // main sequence after a four-cycle reset
  initial begin
    clk_i   = 1'b0;
    rst_i   = 1'b1;
    wr_i    = 1'b0;
    rd_i    = 1'b0;
    addr_i  = 8'h0;
    wdata_i = 32'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_causes();
    t_addr();
    t_escal();
    t_lock();
    results();
  end
  // watchdog, about 24 times the expected run
  initial begin
    #50000;
    error_cnt++;
    results();
  end
endmodule : fault_unit_tb
